// >>> dv/fpu_register_move_unit_tb.sv
// Purpose: both ends joined, checked against a register model
// Assumes: bench keeps alignment spacing between instructions
// Notes:   condition nibble sits in the low opcode bits, every code is driven
`timescale 1ns/1ps
`default_nettype none
module fpu_register_move_unit_tb;
   logic        clk_sys, sys_rst, user_valid, move_taken;
   logic [31:0] user_insn, user_mem, user_temp, user_acc, user_prod, aux_readback, status_word;
   logic [2:0]  user_aux_sel;
   logic [31:0] fr [8];
   logic [31:0] ax [8];
   logic [31:0] rnd, tv, av, pv;
   logic [6:0]  st;
   int          n_errors, comparisons;
   frmu_if link_if ();
   frmu_device u_frmu_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_if),
      .status_word(status_word), .move_taken(move_taken));
   frmu_host u_frmu_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_if), .user_valid(user_valid),
      .user_insn(user_insn), .user_mem(user_mem), .user_temp(user_temp), .user_acc(user_acc),
      .user_prod(user_prod), .user_aux_sel(user_aux_sel), .aux_readback(aux_readback));
   frmu_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .insn_valid(link_if.insn_valid),
      .insn_word(link_if.insn_word), .memory_operand(link_if.memory_operand), .host_wr(link_if.host_wr),
      .host_wr_idx(link_if.host_wr_idx), .status_word(status_word), .move_taken(move_taken));
   // free running system clock
   always #5 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] mk(input logic [2:0] s, input logic [2:0] d, input logic [15:0] lo);
      return {10'h000, s, d, lo};
   endfunction
   // condition model written from the code table
   function automatic logic cnd_ok(input logic [3:0] c, input logic [6:0] s);
      case (c)
         4'h0: return !s[frmu_pkg::SB_ZF];
         4'h1: return s[frmu_pkg::SB_ZF];
         4'h2: return !s[frmu_pkg::SB_ZF] && !s[frmu_pkg::SB_NF];
         4'h3: return !s[frmu_pkg::SB_NF];
         4'h4: return s[frmu_pkg::SB_NF];
         4'h5: return s[frmu_pkg::SB_ZF] && s[frmu_pkg::SB_NF];
         4'ha: return s[frmu_pkg::SB_TF];
         4'hb: return !s[frmu_pkg::SB_TF];
         4'hc: return s[frmu_pkg::SB_LUF];
         4'hd: return s[frmu_pkg::SB_LVF];
         4'he: return 1'b1;
         4'hf: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic summarize();
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one instruction, model updated alongside; seven idle cycles cover alignment
   task automatic issue(input logic [31:0] w, input logic [31:0] m);
      logic [7:0]  loc;
      logic [31:0] v;
      logic        tk;
      loc = w[7:0];
      tk = 1'b0;
      @(posedge clk_sys);
      rnd = lfsr(rnd); tv = rnd; rnd = lfsr(rnd); av = rnd; rnd = lfsr(rnd); pv = rnd;
      user_valid <= 1'b1; user_insn <= w; user_mem <= m;
      user_temp <= tv; user_acc <= av; user_prod <= pv;
      if (w[15:4] === frmu_pkg::OPC_REG_MOVE[15:4]) begin
         v = fr[w[21:19]];
         if (cnd_ok(w[3:0], st)) begin
            fr[w[18:16]] = v;
            tk = 1'b1;
         end
         // only the flagging code touches the four result flags
         if (w[3:0] == 4'hf) begin
            st[frmu_pkg::SB_NF] = v[31] && v[30:23] != 8'h00;
            st[frmu_pkg::SB_ZF] = v[30:23] == 8'h00;
            st[frmu_pkg::SB_NI] = v[31];
            st[frmu_pkg::SB_ZI] = v == 32'h0000_0000;
         end
      end else if (w[15:0] === frmu_pkg::OPC_STATUS_LD) st = m[6:0];
      else if (w[15:8] === frmu_pkg::OPC_FROM_HOST)
         fr[w[18:16]] = loc < 8 ? ax[loc[2:0]] : loc == frmu_pkg::LOC_TEMP ? tv : loc == frmu_pkg::LOC_ACC ? av : pv;
      else if (w[15:8] === frmu_pkg::OPC_TO_HOST) ax[w[2:0]] = fr[w[18:16]];
      @(posedge clk_sys);
      user_valid <= 1'b0;
      // move pulse stands one cycle after the unit acts
      @(posedge clk_sys);
      @(negedge clk_sys);
      comparisons++;
      if (move_taken !== tk) begin
         n_errors++;
         $display("CHECK FAILED %0t move pulse mismatch", $time);
      end
      repeat (5) @(posedge clk_sys);
   endtask
   // read every auxiliary register back, then the flags
   task automatic check_all();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         user_aux_sel <= i[2:0];
         repeat (2) @(posedge clk_sys);
         comparisons++;
         if (aux_readback !== ax[i]) begin
            n_errors++;
            $display("CHECK FAILED %0t aux %0d mismatch", $time, i);
         end
      end
      comparisons++;
      if (status_word[6:0] !== st) begin
         n_errors++;
         $display("CHECK FAILED %0t status mismatch", $time);
      end
   endtask
   // hang guard, far beyond the roughly eight hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial begin
      clk_sys = 1'b0; sys_rst = 1'b1; user_valid = 1'b0; user_insn = '0; user_mem = '0;
      user_temp = '0; user_acc = '0; user_prod = '0; user_aux_sel = '0;
      rnd = 32'h0000_0019; st = '0; n_errors = 0; comparisons = 0;
      for (int i = 0; i < 8; i++) begin fr[i] = '0; ax[i] = '0; end
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      issue(mk(3'h1, 3'h2, frmu_pkg::OPC_REG_MOVE | 16'h000f), '0);
      check_all();
      // temp, accumulator and product in turn, one into each float register, then out
      for (int i = 0; i < 8; i++) begin
         issue(mk(3'h0, i[2:0], {frmu_pkg::OPC_FROM_HOST, 8'h08 + 8'(i % 3)}), '0);
         issue(mk(3'h0, i[2:0], {frmu_pkg::OPC_TO_HOST, 8'(7 - i)}), '0);
      end
      check_all();
      // auxiliary round trip through the float file
      for (int i = 0; i < 8; i++) begin
         issue(mk(3'h0, i[2:0], {frmu_pkg::OPC_FROM_HOST, 8'(i ^ 1)}), '0);
         issue(mk(3'h0, i[2:0], {frmu_pkg::OPC_TO_HOST, 8'(i)}), '0);
      end
      check_all();
      // every condition code against random flags
      for (int k = 0; k < 16; k++) begin
         rnd = lfsr(rnd);
         issue(mk(3'h0, 3'h0, frmu_pkg::OPC_STATUS_LD), rnd);
         issue(mk(3'(k + 4), 3'(k), frmu_pkg::OPC_REG_MOVE | 16'(k)), '0);
         issue(mk(3'h0, 3'(k), {frmu_pkg::OPC_TO_HOST, 8'(k)}), '0);
      end
      check_all();
      // an unknown word and a move with undefined condition code 6 must leave everything alone
      issue(32'h0000_1234, 32'hffff_ffff);
      issue(mk(3'h1, 3'h2, 16'he6c6), '0);
      check_all();
      summarize();
   end
endmodule // fpu_register_move_unit_tb
`default_nettype wire

// >>> dv/frmu_props.sv
// Purpose: link and status checks for the float move unit
// Assumes: one clock, synchronous high reset
// Notes:   status load is judged on the seven flags only; stability checks cover the whole word
`timescale 1ns/1ps
`default_nettype none
module frmu_props (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // link signals
   input wire logic        insn_valid,
   input wire logic [31:0] insn_word,
   input wire logic [31:0] memory_operand,
   input wire logic        host_wr,
   input wire logic [2:0]  host_wr_idx,
   // device user side
   input wire logic [31:0] status_word,
   input wire logic        move_taken
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // decoded kind of the offered instruction
   wire logic rmv = insn_valid && insn_word[15:4] == frmu_pkg::OPC_REG_MOVE[15:4];
   wire logic sld = insn_valid && insn_word[15:0] == frmu_pkg::OPC_STATUS_LD;
   wire logic toh = insn_valid && insn_word[15:8] == frmu_pkg::OPC_TO_HOST;
   wire logic frh = insn_valid && insn_word[15:8] == frmu_pkg::OPC_FROM_HOST;
   wire logic bad = insn_valid && !(rmv || sld || toh || frh);
   a_to_host_write: assert property (toh |=> host_wr && host_wr_idx == $past(insn_word[2:0]))
      else $error("copy to host gave no write");
   a_write_cause: assert property (host_wr |-> $past(toh))
      else $error("host write without copy");
   a_status_load: assert property (sld |=> status_word[6:0] == $past(memory_operand[6:0]))
      else $error("status load lost flags");
   a_move_flags: assert property (rmv && insn_word[3:0] != 4'hf |=> $stable(status_word))
      else $error("move changed flags");
   a_host_flags: assert property ((toh || frh) |=> $stable(status_word))
      else $error("host copy changed flags");
   a_move_when_true: assert property (rmv && insn_word[3:0] == 4'h0 && !status_word[frmu_pkg::SB_ZF] |=> move_taken)
      else $error("true condition gave no move");
   a_move_when_false: assert property (rmv && insn_word[3:0] == 4'h0 && status_word[frmu_pkg::SB_ZF] |=> !move_taken)
      else $error("false condition moved");
   a_move_cause: assert property (move_taken |-> $past(rmv))
      else $error("move without move opcode");
   a_refused_quiet: assert property (bad |=> $stable(status_word) && !move_taken && !host_wr)
      else $error("unknown opcode acted");
   // main scenarios
   c_move: cover property (rmv && !status_word[frmu_pkg::SB_ZF]);
   c_load: cover property (sld);
   c_out: cover property (toh);
endmodule // frmu_props
`default_nettype wire

// >>> logic/frmu_device.sv
// Purpose: float register file, status word and move decoder
// Assumes: issuer honours alignment spacing and legal condition codes
// Notes:   no interlock; early reads of a fresh register are undefined
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module frmu_device (
   // clock and reset
   input  wire logic   clk_sys,
   input  wire logic   sys_rst,
   // link to host core
   frmu_if.device      link,
   // user side observation
   output logic [31:0] status_word,
   output logic        move_taken
);
   typedef struct packed {
      logic [7:0][31:0] fregs;
      logic [31:0]      status;
      logic             taken;
      logic             hwr;
      logic [2:0]       hidx;
      logic [31:0]      hdata;
   } frmu_dev_state_t;

   frmu_dev_state_t state_reg;
   frmu_dev_state_t state_next;

   // condition evaluation against current flags
   function automatic logic cond_true(input logic [3:0] c, input logic [31:0] s);
      logic r;
      r = 1'b0;
      case (frmu_pkg::frmu_cond_t'(c))
         frmu_pkg::nonzero_cond:           r = !s[frmu_pkg::SB_ZF];
         frmu_pkg::zero_cond:              r = s[frmu_pkg::SB_ZF];
         frmu_pkg::positive_cond:          r = !s[frmu_pkg::SB_ZF] && !s[frmu_pkg::SB_NF];
         frmu_pkg::nonnegative_cond:       r = !s[frmu_pkg::SB_NF];
         frmu_pkg::negative_cond:          r = s[frmu_pkg::SB_NF];
         frmu_pkg::nonpositive_cond:       r = s[frmu_pkg::SB_ZF] && s[frmu_pkg::SB_NF];
         frmu_pkg::test_set_cond:          r = s[frmu_pkg::SB_TF];
         frmu_pkg::test_clear_cond:        r = !s[frmu_pkg::SB_TF];
         frmu_pkg::underflow_latched_cond: r = s[frmu_pkg::SB_LUF];
         frmu_pkg::overflow_latched_cond:  r = s[frmu_pkg::SB_LVF];
         frmu_pkg::always_cond:            r = 1'b1;
         frmu_pkg::always_flagging_cond:   r = 1'b1;
         default:                          r = 1'b0;
      endcase
      return r;
   endfunction

   // decode of the instruction word
   function automatic frmu_pkg::frmu_op_t decode(input logic [31:0] w);
      frmu_pkg::frmu_op_t op;
      op = frmu_pkg::OP_NONE;
      // fixed low word, condition nibble in [3:0] left free
      if (w[15:4] == frmu_pkg::OPC_REG_MOVE[15:4]) begin
         op = frmu_pkg::OP_REG_MOVE;
      end else if (w[15:0] == frmu_pkg::OPC_STATUS_LD) begin
         op = frmu_pkg::OP_STATUS_LD;
      end else if (w[15:8] == frmu_pkg::OPC_FROM_HOST) begin
         op = frmu_pkg::OP_FROM_HOST;
      end else if (w[15:8] == frmu_pkg::OPC_TO_HOST) begin
         op = frmu_pkg::OP_TO_HOST;
      end
      return op;
   endfunction

   // next state
   always_comb begin
      logic [2:0]  src;
      logic [2:0]  dst;
      logic [3:0]  cnd;
      logic [31:0] val;
      logic [7:0]  loc;
      src = link.insn_word[frmu_pkg::SRC_LSB +: 3];
      dst = link.insn_word[frmu_pkg::DST_LSB +: 3];
      cnd = link.insn_word[frmu_pkg::COND_LSB +: 4];
      loc = link.insn_word[7:0];
      val = state_reg.fregs[src];
      state_next = state_reg;
      state_next.taken = 1'b0;
      state_next.hwr = 1'b0;
      // no interlock, every issue acts at once
      if (link.insn_valid) begin
         case (decode(link.insn_word))
            frmu_pkg::OP_REG_MOVE: begin
               if (cond_true(cnd, state_reg.status)) begin
                  state_next.fregs[dst] = val;
                  state_next.taken = 1'b1;
               end
               if (cnd == frmu_pkg::always_flagging_cond) begin
                  state_next.status[frmu_pkg::SB_NF] = val[31];
                  state_next.status[frmu_pkg::SB_ZF] = 1'b0;
                  if (val[30:23] == frmu_pkg::EXP_ZERO) begin
                     state_next.status[frmu_pkg::SB_ZF] = 1'b1;
                     state_next.status[frmu_pkg::SB_NF] = 1'b0;
                  end
                  state_next.status[frmu_pkg::SB_NI] = val[31];
                  state_next.status[frmu_pkg::SB_ZI] = (val == frmu_pkg::WORD_ZERO);
               end
            end
            frmu_pkg::OP_STATUS_LD: begin
               state_next.status = link.memory_operand;
            end
            frmu_pkg::OP_FROM_HOST: begin
               // aux source, temp, acc or product
               if (loc == frmu_pkg::LOC_TEMP) begin
                  state_next.fregs[link.insn_word[18:16]] = link.temp_reg;
               end else if (loc == frmu_pkg::LOC_ACC) begin
                  state_next.fregs[link.insn_word[18:16]] = link.acc_val;
               end else if (loc == frmu_pkg::LOC_PROD) begin
                  state_next.fregs[link.insn_word[18:16]] = link.prod_val;
               end else begin
                  state_next.fregs[link.insn_word[18:16]] = link.aux_val;
               end
            end
            frmu_pkg::OP_TO_HOST: begin
               state_next.hwr = 1'b1;
               state_next.hidx = loc[2:0];
               state_next.hdata = state_reg.fregs[link.insn_word[18:16]];
            end
            default: begin
               state_next.taken = 1'b0;
            end
         endcase
      end
   end

   // state register, synchronous reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign link.host_wr      = state_reg.hwr;
   assign link.host_wr_idx  = state_reg.hidx;
   assign link.host_wr_data = state_reg.hdata;
   assign status_word       = state_reg.status;
   assign move_taken        = state_reg.taken;
endmodule : frmu_device
`default_nettype wire

// >>> logic/frmu_host.sv
// Purpose: host side issuer with auxiliary register file
// Assumes: user presents one instruction at a time
// Notes:   issuer does not pad alignment slots; the user must
`timescale 1ns/1ps
`default_nettype none
module frmu_host (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // link to float unit
   frmu_if.host             link,
   // user instruction port
   input  wire logic        user_valid,
   input  wire logic [31:0] user_insn,
   input  wire logic [31:0] user_mem,
   input  wire logic [31:0] user_temp,
   input  wire logic [31:0] user_acc,
   input  wire logic [31:0] user_prod,
   input  wire logic [2:0]  user_aux_sel,
   // auxiliary register readback
   output logic [31:0]      aux_readback
);
   typedef struct packed {
      logic [7:0][31:0] aux;
      logic             v;
      logic [31:0]      insn;
      logic [31:0]      mem;
      logic [31:0]      temp;
      logic [31:0]      acc;
      logic [31:0]      prod;
      logic [31:0]      auxv;
      logic [31:0]      rb;
   } frmu_host_state_t;

   frmu_host_state_t state_reg;
   frmu_host_state_t state_next;

   // register issue and capture results; left to user spacing
   always_comb begin
      state_next = state_reg;
      state_next.v = user_valid;
      state_next.insn = user_insn;
      state_next.mem = user_mem;
      state_next.temp = user_temp;
      state_next.acc = user_acc;
      state_next.prod = user_prod;
      // aux value selected by location field
      state_next.auxv = state_reg.aux[user_insn[2:0]];
      if (link.host_wr) begin
         state_next.aux[link.host_wr_idx] = link.host_wr_data;
      end
      state_next.rb = state_next.aux[user_aux_sel];
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign link.insn_valid     = state_reg.v;
   assign link.insn_word      = state_reg.insn;
   assign link.memory_operand = state_reg.mem;
   assign link.temp_reg       = state_reg.temp;
   assign link.acc_val        = state_reg.acc;
   assign link.prod_val       = state_reg.prod;
   assign link.aux_val        = state_reg.auxv;
   assign aux_readback        = state_reg.rb;
endmodule : frmu_host
`default_nettype wire

// >>> logic/frmu_if.sv
// Purpose: link between the host core and the float move unit
// Assumes: one clock, issuer keeps the alignment spacing
// Notes:   instruction pulses for one cycle, results are registered
`timescale 1ns/1ps
`default_nettype none
interface frmu_if;
   // instruction issue
   logic        insn_valid;
   logic [31:0] insn_word;
   logic [31:0] memory_operand;
   // host register values offered to the unit
   logic [31:0] aux_val;
   logic [31:0] temp_reg;
   logic [31:0] acc_val;
   logic [31:0] prod_val;
   // unit answer toward the host register file
   logic        host_wr;
   logic [2:0]  host_wr_idx;
   logic [31:0] host_wr_data;
   modport device (input insn_valid, insn_word, memory_operand, aux_val, temp_reg, acc_val, prod_val,
                   output host_wr, host_wr_idx, host_wr_data);
   modport host   (output insn_valid, insn_word, memory_operand, aux_val, temp_reg, acc_val, prod_val,
                   input host_wr, host_wr_idx, host_wr_data);
endinterface : frmu_if
`default_nettype wire

// >>> logic/frmu_pkg.sv
// Purpose: shared constants and types for the float register move unit
// Assumes: 32-bit instruction words, low word in [15:0], high word in [31:16]
// Notes:   flag positions in the status word are a local layout
`default_nettype none
package frmu_pkg;
   // opcode low words and bytes
   localparam logic [15:0] OPC_REG_MOVE   = 16'he6c0;
   localparam logic [15:0] OPC_STATUS_LD  = 16'he280;
   localparam logic [7:0]  OPC_FROM_HOST  = 8'hbd;
   localparam logic [7:0]  OPC_TO_HOST    = 8'hbf;
   // field positions for the register move, source and destination in the high word, condition in the low word
   localparam int SRC_LSB   = 19;
   localparam int DST_LSB   = 16;
   localparam int COND_LSB  = 0;
   localparam int ZERO_HI   = 31;
   localparam int ZERO_LO   = 22;
   // location field: bits [7:0] of low word
   localparam int LOC_SRC_LSB = 3;
   // condition codes
   typedef enum logic [3:0] {
      nonzero_cond           = 4'h0,
      zero_cond              = 4'h1,
      positive_cond          = 4'h2,
      nonnegative_cond       = 4'h3,
      negative_cond          = 4'h4,
      nonpositive_cond       = 4'h5,
      test_set_cond          = 4'ha,
      test_clear_cond        = 4'hb,
      underflow_latched_cond = 4'hc,
      overflow_latched_cond  = 4'hd,
      always_cond            = 4'he,
      always_flagging_cond   = 4'hf
   } frmu_cond_t;
   // status word bit positions
   localparam int SB_LVF = 0;
   localparam int SB_LUF = 1;
   localparam int SB_NF  = 2;
   localparam int SB_ZF  = 3;
   localparam int SB_NI  = 4;
   localparam int SB_ZI  = 5;
   localparam int SB_TF  = 6;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   localparam logic [7:0]  EXP_ZERO     = 8'h00;
   // operation kinds
   typedef enum logic [2:0] {
      OP_NONE      = 3'b000,
      OP_REG_MOVE  = 3'b001,
      OP_STATUS_LD = 3'b010,
      OP_FROM_HOST = 3'b011,
      OP_TO_HOST   = 3'b100
   } frmu_op_t;
   // host source selection for copies into the float file
   typedef enum logic [1:0] {
      SRC_AUX  = 2'b00,
      SRC_TEMP = 2'b01,
      SRC_ACC  = 2'b10,
      SRC_PROD = 2'b11
   } frmu_hsrc_t;
   localparam logic [7:0] LOC_TEMP = 8'h08;
   localparam logic [7:0] LOC_ACC  = 8'h09;
   localparam logic [7:0] LOC_PROD = 8'h0a;
   localparam int ALIGN_FROM_HOST = 4;
   localparam int ALIGN_TO_HOST_1 = 1;
   localparam int ALIGN_TO_HOST_2 = 2;
endpackage : frmu_pkg
`default_nettype wire
